// File: inc/csw_map.vh
// csw_map.vh: register offsets, field positions and reset values of the switch block
// assumes inclusion by bare name from the design files
`ifndef CSW_MAP_VH
`define CSW_MAP_VH
`define CSW_ADDR_W 4
`define CSW_SWITCH_CONFIGURATION_OFFSET 4'h0
`define CSW_STATUS_OFFSET 4'h4
`define CSW_SWITCH_CONFIGURATION_RESET 8'h00
`define CSW_A_SEL_LSB 0
`define CSW_B_SEL_LSB 2
`define CSW_TX_SEL_LSB 4
`define CSW_A_EN_BIT 6
`define CSW_B_EN_BIT 7
`define CSW_BUS_INVALID 2'h0
`define CSW_BUS_RECEIVER 2'h1
`define CSW_BUS_A_REQUEST 2'h2
`define CSW_BUS_B_REQUEST 2'h3
`define CSW_TM_ACTIVE 3'h0
`define CSW_HALT_PAIRS 4'h8
`define CSW_SYM_HALT 10'h0e4
`define CSW_SYM_IDLE 10'h3ff
`define CSW_RESP_OKAY 2'h0
`define CSW_RESP_SLVERR 2'h2
`endif

// File: core/csw_bus_mux.v
// csw_bus_mux.v: four-way selector of the switch data buses, 10 bits wide
// assumes the selector and all buses are stable in the mclk domain
`default_nettype none
`include "csw_map.vh"
module csw_bus_mux (
  input wire [1:0] sel,
  input wire [9:0] invalidBus,
  input wire [9:0] receiverBus,
  input wire [9:0] aRequestBus,
  input wire [9:0] bRequestBus,
  output reg [9:0] busOut
);
  always @* begin
    case (sel)
      `CSW_BUS_INVALID: busOut = invalidBus;
      `CSW_BUS_RECEIVER: busOut = receiverBus;
      `CSW_BUS_A_REQUEST: busOut = aRequestBus;
      `CSW_BUS_B_REQUEST: busOut = bRequestBus;
      default: busOut = invalidBus;
    endcase
  end
endmodule // csw_bus_mux
`default_nettype wire

// File: core/csw_halt_gen.v
// csw_halt_gen.v: on the invalid source in active transmit mode, a bounded
// run of halt pairs and then idle, as the repeat filter's repeat state does
// assumes one clock, mclk, and synchronous inputs
`default_nettype none
`include "csw_map.vh"
module csw_halt_gen (
  input wire mclk,
  input wire reset,
  input wire repeatActive,
  output reg [9:0] fillSymbol
);
  localparam IDLE = 2'h0;
  localparam HALT = 2'h1;
  localparam FILL = 2'h2;
  reg [1:0] state;
  reg [3:0] pairCount;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= IDLE;
      pairCount <= 4'h0;
      fillSymbol <= `CSW_SYM_IDLE;
    end else begin
      case (state)
        IDLE: begin
          fillSymbol <= `CSW_SYM_IDLE;
          pairCount <= 4'h0;
          if (repeatActive) begin
            state <= HALT;
            fillSymbol <= `CSW_SYM_HALT;
          end
        end
        HALT: begin
          if (!repeatActive) begin
            state <= IDLE;
            fillSymbol <= `CSW_SYM_IDLE;
          end else if (pairCount == `CSW_HALT_PAIRS - 4'h1) begin
            // bounded halt run, then idle until repeatActive drops
            state <= FILL;
            fillSymbol <= `CSW_SYM_IDLE;
          end else begin
            pairCount <= pairCount + 4'h1;
            fillSymbol <= `CSW_SYM_HALT;
          end
        end
        FILL: begin
          fillSymbol <= `CSW_SYM_IDLE;
          if (!repeatActive) begin
            state <= IDLE;
          end
        end
        default: begin
          state <= IDLE;
          fillSymbol <= `CSW_SYM_IDLE;
        end
      endcase
    end
  end
endmodule // csw_halt_gen
`default_nettype wire

// File: core/csw_config_switch.v
// csw_config_switch.v: configuration switch register and bus routing, AXI4-Lite slave
// assumes mclk at 10 MHz, synchronous inputs, a single AXI4-Lite master
// What this block does
// - bits 0-1 pick bus for A port
// - bits 2-3 pick bus for B port
// - B field writable even without B port
// - bits 4-5 pick transmitter source bus
// - invalid source, active mode: halts, then idle
// - bit 6 low disables A port
// - bit 7 low disables B port
// - disabled port floats, as does B without a B port; enabled drives selection
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`default_nettype none
`include "csw_map.vh"
module csw_config_switch (
  input wire mclk,
  input wire reset,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire bPortPresent,
  input wire [2:0] transmitModeField,
  input wire [9:0] invalidBus,
  input wire [9:0] receiverBus,
  input wire [9:0] aRequestBus,
  input wire [9:0] bRequestBus,
  output reg aPortParity,
  output reg aPortControl,
  output reg [7:0] aPortData,
  output reg aPortOe_n,
  output reg bPortParity,
  output reg bPortControl,
  output reg [7:0] bPortData,
  output reg bPortOe_n,
  output reg [9:0] transmitBus
);
  reg [7:0] switchConfiguration;
  reg [3:0] awAddr;
  reg awHeld;
  reg [31:0] wData;
  reg [3:0] wStrb;
  reg wHeld;
  wire [9:0] aSel;
  wire [9:0] bSel;
  wire [9:0] txSel;
  wire [9:0] fillSymbol;
  wire txInvalid;
  wire [3:0] curAw;
  wire [31:0] curW;
  wire [3:0] curStrb;
  wire haveAw;
  wire haveW;
  wire doWrite;

  assign curAw = awHeld ? awAddr : s_axi_awaddr;
  assign curW = wHeld ? wData : s_axi_wdata;
  assign curStrb = wHeld ? wStrb : s_axi_wstrb;
  assign haveAw = awHeld | (s_axi_awvalid & s_axi_awready);
  assign haveW = wHeld | (s_axi_wvalid & s_axi_wready);
  assign doWrite = haveAw & haveW & ~s_axi_bvalid;

  csw_bus_mux aMux (
    .sel(switchConfiguration[`CSW_A_SEL_LSB +: 2]),
    .invalidBus(invalidBus),
    .receiverBus(receiverBus),
    .aRequestBus(aRequestBus),
    .bRequestBus(bRequestBus),
    .busOut(aSel)
  );
  csw_bus_mux bMux (
    .sel(switchConfiguration[`CSW_B_SEL_LSB +: 2]),
    .invalidBus(invalidBus),
    .receiverBus(receiverBus),
    .aRequestBus(aRequestBus),
    .bRequestBus(bRequestBus),
    .busOut(bSel)
  );
  csw_bus_mux txMux (
    .sel(switchConfiguration[`CSW_TX_SEL_LSB +: 2]),
    .invalidBus(invalidBus),
    .receiverBus(receiverBus),
    .aRequestBus(aRequestBus),
    .bRequestBus(bRequestBus),
    .busOut(txSel)
  );

  assign txInvalid = (switchConfiguration[`CSW_TX_SEL_LSB +: 2] == `CSW_BUS_INVALID) &&
                     (transmitModeField == `CSW_TM_ACTIVE);
  csw_halt_gen haltGen (
    .mclk(mclk),
    .reset(reset),
    .repeatActive(txInvalid),
    .fillSymbol(fillSymbol)
  );

  // write channels taken in either order; each is held until both are in
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CSW_RESP_OKAY;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 4'h0;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      switchConfiguration <= `CSW_SWITCH_CONFIGURATION_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr <= s_axi_awaddr;
        awHeld <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        wHeld <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (curAw[3:2] == `CSW_SWITCH_CONFIGURATION_OFFSET >> 2) begin
          s_axi_bresp <= `CSW_RESP_OKAY;
          // B field stored even where no B port exists
          if (curStrb[0]) begin
            switchConfiguration <= curW[7:0];
          end
        end else if (curAw[3:2] == `CSW_STATUS_OFFSET >> 2) begin
          s_axi_bresp <= `CSW_RESP_OKAY;
        end else begin
          s_axi_bresp <= `CSW_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CSW_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CSW_RESP_OKAY;
        case (s_axi_araddr[3:2])
          2'h0: s_axi_rdata <= {24'h000000, switchConfiguration};
          2'h1: s_axi_rdata <= {19'h00000, txInvalid, bPortPresent, fillSymbol, 1'b0};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CSW_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // port outputs registered; enables take effect one cycle after the register
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      aPortParity <= 1'b0;
      aPortControl <= 1'b0;
      aPortData <= 8'h00;
      aPortOe_n <= 1'b1;
      bPortParity <= 1'b0;
      bPortControl <= 1'b0;
      bPortData <= 8'h00;
      bPortOe_n <= 1'b1;
      transmitBus <= `CSW_SYM_IDLE;
    end else begin
      aPortParity <= aSel[9];
      aPortControl <= aSel[8];
      aPortData <= aSel[7:0];
      aPortOe_n <= ~switchConfiguration[`CSW_A_EN_BIT];
      bPortParity <= bSel[9];
      bPortControl <= bSel[8];
      bPortData <= bSel[7:0];
      // no B port: pins never driven
      bPortOe_n <= ~(switchConfiguration[`CSW_B_EN_BIT] & bPortPresent);
      transmitBus <= txInvalid ? fillSymbol : txSel;
    end
  end
endmodule // csw_config_switch
`default_nettype wire

// File: test/csw_switch_asserts.sv
// csw_switch_asserts.sv: port checks of the configuration switch
// assumes bind onto csw_config_switch; writes go to offset 0 only
`default_nettype none
`include "csw_map.vh"
module csw_switch_chk (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic bPortPresent,
  input wire logic [2:0] transmitModeField,
  input wire logic [9:0] invalidBus,
  input wire logic [9:0] receiverBus,
  input wire logic [9:0] aRequestBus,
  input wire logic [9:0] bRequestBus,
  input wire logic [7:0] aPortData,
  input wire logic aPortOe_n,
  input wire logic [7:0] bPortData,
  input wire logic bPortOe_n,
  input wire logic [9:0] transmitBus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cfg;
  logic [7:0] wq;
  wire [39:0] buses = {bRequestBus, aRequestBus, receiverBus, invalidBus};
  wire run = cfg[5:4] == `CSW_BUS_INVALID && transmitModeField == `CSW_TM_ACTIVE;
  function automatic logic [9:0] pick(input logic [1:0] s, input logic [39:0] b);
    return b[s*10 +: 10];
  endfunction
  // shadow lags the register one edge, as the port outputs do
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      cfg <= `CSW_SWITCH_CONFIGURATION_RESET;
      wq <= 8'h00;
    end else begin
      if (s_axi_wvalid && s_axi_wready) wq <= s_axi_wdata[7:0];
      // bvalid stands one cycle per write here; wq cannot move while it stands
      if (s_axi_bvalid) cfg <= wq;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  a_port_route_a: assert property (
    !aPortOe_n |-> aPortData == 8'(pick(cfg[1:0], $past(buses)))) else $error("a port route");
  b_port_route_a: assert property (
    !bPortOe_n |-> bPortData == 8'(pick(cfg[3:2], $past(buses)))) else $error("b port route");
  tx_route_a: assert property (
    cfg[5:4] != 2'h0 |-> transmitBus == pick(cfg[5:4], $past(buses))) else $error("tx route");
  a_port_enable_a: assert property (
    aPortOe_n == !cfg[6]) else $error("a port enable");
  b_port_enable_a: assert property (
    $stable(bPortPresent) |-> bPortOe_n == !(cfg[7] && bPortPresent)) else $error("b enable");
  halt_start_a: assert property (
    $rose(run) |-> ##[1:4] transmitBus == `CSW_SYM_HALT) else $error("no halt run");
  idle_after_a: assert property (
    run [*8] ##1 run [*8] |-> transmitBus == `CSW_SYM_IDLE) else $error("no idle");
  cfg_read_a: assert property (
    $rose(s_axi_rvalid) && $past(s_axi_araddr) == `CSW_SWITCH_CONFIGURATION_OFFSET
    |-> s_axi_rdata == {24'h0, cfg}) else $error("config readback");
endmodule // csw_switch_chk
bind csw_config_switch csw_switch_chk chk_u (.*);
`default_nettype wire

// File: test/csw_mac_model.sv
// csw_mac_model.sv: request-side logic model driving both request buses
// assumes mclk domain; aReq changes every cycle, bReq except when aReq is 3ff, so stale routing shows
`default_nettype none
module csw_mac_model (
  input wire logic mclk,
  input wire logic reset,
  output logic [9:0] aReq,
  output logic [9:0] bReq
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      aReq <= 10'h155;
      bReq <= 10'h2aa;
    end else begin
      aReq <= aReq + 10'h0d3;
      bReq <= ~bReq ^ aReq;
    end
  end
endmodule // csw_mac_model
`default_nettype wire

// File: test/tb_config_switch_bus_select.sv
// tb_config_switch_bus_select.sv: self-checking bench of the switch block
// assumes design, request model and checker compiled before it
`default_nettype none
`include "csw_map.vh"
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %0t got %h want %h", $time, g, e); end end
module tb_config_switch_bus_select;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic bPresent = 1;
  logic [3:0] araddr = 0;
  logic [7:0] wdata = 0;
  logic [2:0] txMode = 0;
  logic [9:0] invBus = 0, rxBus = 0;
  wire [9:0] aReq, bReq, txBus;
  wire awready, wready, bvalid, arready, rvalid, aPar, aCtl, aOe_n, bPar, bCtl, bOe_n;
  wire [7:0] aDat, bDat;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  // pins float while the output enable is high
  wire [9:0] aWire = aOe_n ? 10'bz : {aPar, aCtl, aDat};
  wire [9:0] bWire = bOe_n ? 10'bz : {bPar, bCtl, bDat};
  int mismatches = 0, totalChecks = 0, cyc = 0, seed = 12;
  logic [33:0] expQ [$];
  logic [1:0] expB [$];
  always #50 mclk = ~mclk;
  csw_config_switch dut_u (.mclk(mclk), .reset(reset), .s_axi_awaddr(4'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata({24'h0, wdata}),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .bPortPresent(bPresent), .transmitModeField(txMode), .invalidBus(invBus),
    .receiverBus(rxBus), .aRequestBus(aReq), .bRequestBus(bReq), .aPortParity(aPar),
    .aPortControl(aCtl), .aPortData(aDat), .aPortOe_n(aOe_n), .bPortParity(bPar),
    .bPortControl(bCtl), .bPortData(bDat), .bPortOe_n(bOe_n), .transmitBus(txBus));
  csw_mac_model mac_u (.mclk(mclk), .reset(reset), .aReq(aReq), .bReq(bReq));
  always @(posedge mclk) begin
    invBus <= 10'($random(seed));
    rxBus <= 10'($random(seed));
    if (rvalid && rready) `CHK({rresp, rdata}, expQ.pop_front())
    if (bvalid && bready) `CHK(bresp, expB.pop_front())
  end
  task automatic wr(input logic [7:0] d);
    @(posedge mclk);
    expB.push_back(`CSW_RESP_OKAY);
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    @(posedge mclk);
    expQ.push_back(e);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
  endtask
  // port index -1 means the pins must float, transmit index -1 skips the transmit check; buses taken at the launching edge
  task automatic chkp(input int sa, input int sb, input int st);
    logic [9:0] bs [4];
    @(posedge mclk);
    bs = '{invBus, rxBus, aReq, bReq};
    #1;
    `CHK(aWire, sa < 0 ? 10'bz : bs[sa])
    `CHK(bWire, sb < 0 ? 10'bz : bs[sb])
    if (st >= 0) `CHK(txBus, bs[st])
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && totalChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    logic [7:0] v;
    repeat (5) @(posedge mclk);
    reset <= 0;
    for (int s = 0; s < 4; s++) begin
      wr({2'b11, s[1:0], s[1:0], s[1:0]});
      rd(4'h0, {26'h0, 2'b11, s[1:0], s[1:0], s[1:0]});
      chkp(s, s, s == 0 ? -1 : s);
    end
    wr(8'h1b);
    chkp(-1, -1, 1);
    // status word: transmit source not invalid, B port present, idle fill
    rd(4'h4, {21'h000000, 1'b0, 1'b1, `CSW_SYM_IDLE, 1'b0});
    bPresent <= 0;
    wr(8'hd6);
    chkp(2, -1, 1);
    rd(4'h0, {26'h0, 8'hd6});
    bPresent <= 1;
    wr(8'h00);
    repeat (2) @(posedge mclk);
    #1 `CHK(txBus, `CSW_SYM_HALT)
    // halt run is bounded: last halt and first idle at its two ends
    repeat (6) @(posedge mclk);
    #1 `CHK(txBus, `CSW_SYM_HALT)
    @(posedge mclk);
    #1 `CHK(txBus, `CSW_SYM_IDLE)
    repeat (7) @(posedge mclk);
    #1 `CHK(txBus, `CSW_SYM_IDLE)
    @(posedge mclk);
    txMode <= 3'h1;
    repeat (3) @(posedge mclk);
    txMode <= `CSW_TM_ACTIVE;
    repeat (3) @(posedge mclk);
    #1 `CHK(txBus, `CSW_SYM_HALT)
    repeat (6) begin
      v = 8'($random(seed));
      wr(v);
      rd(4'h0, {26'h0, v});
    end
    rd(4'h8, {`CSW_RESP_SLVERR, 32'h0});
    @(posedge mclk);
    wrap_up();
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 2000) begin
      mismatches++;
      wrap_up();
    end
  end
endmodule // tb_config_switch_bus_select
`default_nettype wire
